//--- pkg/dmrc_pkg.sv
// Constants for the DRAM mode register configuration block
package dmrc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int XP_NS = 6;
   localparam int XPDLL_NS = 24;
   localparam int TRP_NS = 15;
   localparam int XP_CYC = (XP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XPDLL_CYC = (XPDLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRP_CYC = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DLL_LOCK_CYC = 512;
   localparam int ADDR_W = 14;
   localparam int LAT_W = 5;
   localparam int CNT_W = 10;
   localparam int PIPE_D = 32;
   // Command pins {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [2:0] BA_MR0 = 3'h0;
   localparam logic [2:0] BA_MR1 = 3'h1;
   localparam logic [2:0] BA_MR2 = 3'h2;
   // Mode register zero fields
   localparam int MR0_CL0 = 2;
   localparam int MR0_CL1 = 4;
   localparam int MR0_CL2 = 5;
   localparam int MR0_CL3 = 6;
   localparam int MR0_TEST = 7;
   localparam int MR0_DLLRST = 8;
   localparam int MR0_WR_LSB = 9;
   localparam int MR0_PPD = 12;
   // Mode register one fields
   localparam int MR1_DLLDIS = 0;
   localparam int MR1_DIC0 = 1;
   localparam int MR1_RTT0 = 2;
   localparam int MR1_AL_LSB = 3;
   localparam int MR1_DIC1 = 5;
   localparam int MR1_RTT1 = 6;
   localparam int MR1_WLVL = 7;
   localparam int MR1_RTT2 = 9;
   localparam int MR1_TDQS = 11;
   localparam int MR1_QOFF = 12;
   // Mode register two fields
   localparam int MR2_CWL_LSB = 3;
   localparam int MR2_RTTWR_LSB = 9;
   localparam logic [1:0] AL_OFF = 2'h0;
   localparam logic [1:0] AL_CL1 = 2'h1;
   localparam logic [1:0] AL_CL2 = 2'h2;
   localparam logic [1:0] AL_RSVD = 2'h3;
   localparam logic [LAT_W-1:0] CL_BASE_LO = 5'h04;
   localparam logic [LAT_W-1:0] CL_BASE_HI = 5'h0B;
   localparam logic [LAT_W-1:0] CWL_BASE = 5'h05;
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'h0,
      PWR_PDOWN = 2'h1,
      PWR_EXIT = 2'h3,
      PWR_SREF = 2'h2
   } dmrc_pwr_e;
   // Write recovery code to cycles
   function automatic logic [LAT_W-1:0] wr_decode(input logic [2:0] code);
      case (code)
         3'h1: wr_decode = 5'h05;
         3'h2: wr_decode = 5'h06;
         3'h3: wr_decode = 5'h07;
         3'h4: wr_decode = 5'h08;
         3'h5: wr_decode = 5'h0A;
         3'h6: wr_decode = 5'h0C;
         3'h7: wr_decode = 5'h0E;
         default: wr_decode = 5'h10;
      endcase
   endfunction
endpackage

//--- rtl/dmrc_top.sv
// Mode register zero/one/two store, latency decode and DLL control
`timescale 1ns/10ps
`default_nettype none
// Operation
// R01: Column read latency comes from mode register zero bits A2, A4, A5, A6.
// R02: Read latency is additive plus column latency, whole cycles only.
// R03: Controller keeps A7 of register zero low; high means undefined test state.
// R04: DLL reset bit clears itself after the reset action is done.
// R05: Controller waits DLL lock time after any DLL reset before reads.
// R06: Write recovery A9-A11 plus precharge time gives auto-precharge delay.
// R07: Controller programs recovery at least recovery time over period, rounded up.
// R08: A12 selects frozen DLL slow exit or running DLL fast exit.
// R09: Register one is written with BA0 high, other strobes and banks low.
// R10: Controller drives BA2, A8, A10, A13 zero when writing register one.
// R11: Write leveling with outputs on allows only divide-by 2, 4, 6 termination.
// R12: Nominal termination during writes uses only divide-by 2, 4, 6.
// R13: With A0 low, DLL turns off in self refresh, back on at exit.
// R14: Controller holds clock enable high throughout DLL lock time.
// R15: Writes need no DLL unless write-time termination is enabled.
// R16: In DLL-off mode controller disables nominal termination.
// R17: In DLL-off mode controller zeroes dynamic termination in register two.
// R18: Driver impedance is selected by A1 and A5 of register one.
// R19: Nominal termination in register one, write termination in register two.
// R20: Read or write right after activate is delayed by additive latency.
// R21: Additive latency from A4:A3: zero, CL-1, CL-2, or reserved.
// R22: Write latency is additive latency plus column write latency.
// R23: Register zero is written with all strobes and bank bits low.
// R24: Controller changes mode registers only when idle.
// R25: Reserved additive latency code is flagged unsupported, latency forced to zero.
module dmrc_top (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [13:0] addr,
   output logic [4:0] cas_latency,
   output logic [4:0] additive_latency,
   output logic [4:0] read_latency,
   output logic [4:0] write_latency,
   output logic [4:0] autoprecharge_to_activate_delay,
   output logic al_reserved,
   output logic test_mode,
   output logic [1:0] drive_strength,
   output logic [2:0] rtt_nom,
   output logic [1:0] rtt_wr,
   output logic write_leveling,
   output logic tdqs_enable,
   output logic outputs_off,
   output logic dll_running,
   output logic dll_locked,
   output logic write_term_ok,
   output logic cmd_ready,
   output logic rd_issue,
   output logic wr_issue,
   output logic rd_data_start,
   output logic wr_data_start
);
   // ****************************************
   // Command decode
   // ****************************************
   logic [3:0] cmd;
   logic mrs0, mrs1, mrs2, mrs_any, take_rd, take_wr;
   dmrc_pkg::dmrc_pwr_e pwr_q, pwr_d;
   logic [13:0] mr0_q, mr1_q, mr2_q;
   logic dllrst_q, cke_q;
   logic [dmrc_pkg::CNT_W-1:0] lock_q, lock_d;
   logic [3:0] exit_q, exit_d;
   logic [1:0] cmd_pipe_q [dmrc_pkg::PIPE_D];
   logic [dmrc_pkg::PIPE_D-1:0] rd_pipe_q, wr_pipe_q;

   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign mrs0 = cke & (cmd == dmrc_pkg::CMD_MRS) & (ba == dmrc_pkg::BA_MR0);
   assign mrs1 = cke & (cmd == dmrc_pkg::CMD_MRS) & (ba == dmrc_pkg::BA_MR1);
   assign mrs2 = cke & (cmd == dmrc_pkg::CMD_MRS) & (ba == dmrc_pkg::BA_MR2);
   assign take_rd = cmd_ready & cke & (cmd == dmrc_pkg::CMD_RD);
   assign take_wr = cmd_ready & cke & (cmd == dmrc_pkg::CMD_WR);
   assign mrs_any = mrs0 | mrs1 | mrs2;

   // ****************************************
   // Mode registers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mr0_q <= 14'h0000;
         mr1_q <= 14'h0000;
         mr2_q <= 14'h0000;
         dllrst_q <= 1'b0;
         cke_q <= 1'b0;
      end else begin
         if (mrs0) begin // R23
            mr0_q <= addr;
         end
         if (mrs1) begin // R09
            mr1_q <= addr;
         end
         if (mrs2) begin
            mr2_q <= addr;
         end
         dllrst_q <= mrs0 & addr[dmrc_pkg::MR0_DLLRST]; // R04
         cke_q <= cke;
      end
   end

   // ****************************************
   // Latency decode
   // ****************************************
   logic [3:0] cl_code;
   logic [1:0] al_code;
   logic [4:0] cl_v, al_v, cwl_v, wr_v;
   logic dll_en, ppd_fast, dllrst_bit;

   assign cl_code = {mr0_q[dmrc_pkg::MR0_CL0], mr0_q[dmrc_pkg::MR0_CL3],
                     mr0_q[dmrc_pkg::MR0_CL2], mr0_q[dmrc_pkg::MR0_CL1]};
   assign cl_v = (cl_code[3] ? dmrc_pkg::CL_BASE_HI : dmrc_pkg::CL_BASE_LO)
                 + {2'b00, cl_code[2:0]}; // R01
   assign al_code = mr1_q[dmrc_pkg::MR1_AL_LSB +: 2];
   assign al_v = (al_code == dmrc_pkg::AL_CL1) ? cl_v - 5'h01 :
                 (al_code == dmrc_pkg::AL_CL2) ? cl_v - 5'h02 : 5'h00; // R21 R25
   assign cwl_v = dmrc_pkg::CWL_BASE + {2'b00, mr2_q[dmrc_pkg::MR2_CWL_LSB +: 3]};
   assign wr_v = dmrc_pkg::wr_decode(mr0_q[dmrc_pkg::MR0_WR_LSB +: 3]);
   assign dll_en = ~mr1_q[dmrc_pkg::MR1_DLLDIS];
   assign ppd_fast = mr0_q[dmrc_pkg::MR0_PPD];
   assign dllrst_bit = dllrst_q;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cas_latency <= 5'h00;
         additive_latency <= 5'h00;
         read_latency <= 5'h00;
         write_latency <= 5'h00;
         autoprecharge_to_activate_delay <= 5'h00;
         al_reserved <= 1'b0;
         test_mode <= 1'b0;
         drive_strength <= 2'h0;
         rtt_nom <= 3'h0;
         rtt_wr <= 2'h0;
         write_leveling <= 1'b0;
         tdqs_enable <= 1'b0;
         outputs_off <= 1'b0;
      end else begin
         cas_latency <= cl_v;
         additive_latency <= al_v;
         read_latency <= al_v + cl_v; // R02
         write_latency <= al_v + cwl_v; // R22
         autoprecharge_to_activate_delay <= wr_v + 5'(dmrc_pkg::TRP_CYC); // R06
         al_reserved <= (al_code == dmrc_pkg::AL_RSVD); // R25
         test_mode <= mr0_q[dmrc_pkg::MR0_TEST];
         drive_strength <= {mr1_q[dmrc_pkg::MR1_DIC1], mr1_q[dmrc_pkg::MR1_DIC0]}; // R18
         rtt_nom <= {mr1_q[dmrc_pkg::MR1_RTT2], mr1_q[dmrc_pkg::MR1_RTT1],
                     mr1_q[dmrc_pkg::MR1_RTT0]}; // R19
         rtt_wr <= mr2_q[dmrc_pkg::MR2_RTTWR_LSB +: 2]; // R19
         write_leveling <= mr1_q[dmrc_pkg::MR1_WLVL];
         tdqs_enable <= mr1_q[dmrc_pkg::MR1_TDQS];
         outputs_off <= mr1_q[dmrc_pkg::MR1_QOFF];
      end
   end

   // ****************************************
   // Power state and DLL
   // ****************************************
   logic cke_fall, sref_exit;

   assign cke_fall = cke_q & ~cke;
   assign sref_exit = (pwr_q == dmrc_pkg::PWR_SREF) & cke;

   always_comb begin
      pwr_d = pwr_q;
      exit_d = (exit_q != 4'h0) ? exit_q - 4'h1 : 4'h0;
      case (pwr_q)
         dmrc_pkg::PWR_ACTIVE: begin
            if (cke_fall && cmd == dmrc_pkg::CMD_REF) begin
               pwr_d = dmrc_pkg::PWR_SREF;
            end else if (cke_fall) begin
               pwr_d = dmrc_pkg::PWR_PDOWN;
            end
         end
         dmrc_pkg::PWR_PDOWN: begin
            if (cke) begin
               pwr_d = dmrc_pkg::PWR_EXIT;
               exit_d = ppd_fast ? 4'(dmrc_pkg::XP_CYC) : 4'(dmrc_pkg::XPDLL_CYC); // R08
            end
         end
         dmrc_pkg::PWR_SREF: begin
            if (cke) begin
               pwr_d = dmrc_pkg::PWR_EXIT;
               exit_d = 4'(dmrc_pkg::XP_CYC);
            end
         end
         dmrc_pkg::PWR_EXIT: begin
            if (exit_q <= 4'h1) begin
               pwr_d = dmrc_pkg::PWR_ACTIVE;
            end
         end
         default: pwr_d = dmrc_pkg::PWR_ACTIVE;
      endcase
   end

   // DLL relocks after a reset action or after self refresh exit
   always_comb begin
      lock_d = (lock_q != '0) ? lock_q - 10'h001 : lock_q;
      if ((dllrst_bit || sref_exit) && dll_en) begin // R13
         lock_d = 10'(dmrc_pkg::DLL_LOCK_CYC);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pwr_q <= dmrc_pkg::PWR_ACTIVE;
         exit_q <= 4'h0;
         lock_q <= '0;
      end else begin
         pwr_q <= pwr_d;
         exit_q <= exit_d;
         lock_q <= lock_d;
      end
   end

   assign cmd_ready = (pwr_q == dmrc_pkg::PWR_ACTIVE);
   assign dll_running = dll_en & (pwr_q != dmrc_pkg::PWR_SREF)
                        & ~((pwr_q == dmrc_pkg::PWR_PDOWN) & ~ppd_fast); // R13 R08
   assign dll_locked = dll_running & (lock_q == '0);
   assign write_term_ok = (rtt_wr == 2'h0) | dll_locked; // R15

   // ****************************************
   // Additive and column latency pipes
   // ****************************************
   // Mode change flushes stale entries so a new latency cannot replay them
   always_ff @(posedge clk_sys) begin
      if (!resetn || mrs_any) begin
         for (int i = 0; i < dmrc_pkg::PIPE_D; i++) begin
            cmd_pipe_q[i] <= 2'b00;
         end
         rd_pipe_q <= '0;
         wr_pipe_q <= '0;
      end else begin
         cmd_pipe_q[0] <= {take_wr, take_rd}; // R20
         for (int i = 1; i < dmrc_pkg::PIPE_D; i++) begin
            cmd_pipe_q[i] <= cmd_pipe_q[i-1];
         end
         rd_pipe_q <= {rd_pipe_q[dmrc_pkg::PIPE_D-2:0], rd_issue};
         wr_pipe_q <= {wr_pipe_q[dmrc_pkg::PIPE_D-2:0], wr_issue};
      end
   end

   assign rd_issue = cmd_pipe_q[additive_latency][0]; // R20
   assign wr_issue = cmd_pipe_q[additive_latency][1]; // R20
   assign rd_data_start = rd_pipe_q[cas_latency - 5'h01]; // R01
   assign wr_data_start = wr_pipe_q[write_latency - additive_latency - 5'h01]; // R22

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_rst_written;
      mrs0 && addr[dmrc_pkg::MR0_DLLRST];
   endsequence
   sequence s_self_clear;
      dllrst_q ##1 !dllrst_q;
   endsequence

   a_dll_rst_clear: assert property (s_rst_written |=> s_self_clear) // R04
      else $error("DLL reset bit did not clear itself");
   a_lock_wait: assert property ((dllrst_q && dll_en) |=> !dll_locked [*8]) // R05
      else $error("DLL locked too early after reset");
   a_read_sum: assert property (mrs1 |=> ##1 read_latency == additive_latency + cas_latency) // R02
      else $error("Read latency not the sum");
   a_cl_decode: assert property (mrs0 && addr[dmrc_pkg::MR0_CL0] == 1'b0 |=> ##1
      cas_latency == dmrc_pkg::CL_BASE_LO + {2'b00, $past(addr[6:4], 2)}) // R01
      else $error("Column latency decode wrong");
   a_al_minus: assert property (mrs1 && addr[4:3] == dmrc_pkg::AL_CL2 |=> ##1
      additive_latency == cas_latency - 5'h02) // R21
      else $error("Additive latency not CL-2");
   a_al_rsvd: assert property (mrs1 && addr[4:3] == dmrc_pkg::AL_RSVD |=> ##1
      al_reserved && additive_latency == 5'h00) // R25
      else $error("Reserved additive latency not flagged");
   a_sref_dll: assert property (pwr_q == dmrc_pkg::PWR_SREF |-> !dll_running) // R13
      else $error("DLL running in self refresh");
   a_slow_exit: assert property ((pwr_q == dmrc_pkg::PWR_PDOWN && cke && !ppd_fast) |=>
      exit_q == 4'(dmrc_pkg::XPDLL_CYC) && !cmd_ready) // R08
      else $error("Slow exit wait not loaded");
   a_issue_now: assert property ((take_rd && additive_latency == 5'h00) |=> rd_issue) // R20
      else $error("Read not issued with zero additive latency");
   a_write_term: assert property ((rtt_wr != 2'h0 && !dll_locked) |-> !write_term_ok) // R15
      else $error("Write termination allowed without DLL");
   a_dal_sum: assert property (mrs0 |=> ##1 autoprecharge_to_activate_delay ==
      dmrc_pkg::wr_decode(mr0_q[11:9]) + 5'(dmrc_pkg::TRP_CYC)) // R06
      else $error("Auto-precharge delay wrong");
   a_write_sum: assert property (mrs2 |=> ##1 write_latency == additive_latency +
      dmrc_pkg::CWL_BASE + {2'b00, mr2_q[5:3]}) // R22
      else $error("Write latency not the sum");
   a_drive_sel: assert property (mrs1 |=> ##1 drive_strength == {mr1_q[5], mr1_q[1]}) // R18
      else $error("Driver impedance select wrong");
   a_term_hold: assert property (mrs2 |=> ##1 rtt_wr == mr2_q[10:9]) // R19
      else $error("Write termination not held");
   a_mrs_flush: assert property (mrs_any |=> !rd_issue && !wr_issue) // R20
      else $error("Stale command issued after mode change");
endmodule
`default_nettype wire

//--- verification/dmrc_ctrl_model.sv
// Memory controller model driving the command and address pins
`timescale 1ns/10ps
`default_nettype none
module dmrc_ctrl_model (
   input wire logic clk_sys,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] ba,
   output logic [13:0] addr
);
   // Set while the last register one write turned the DLL off
   logic dll_off;
   initial begin
      dll_off = 1'b0;
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      ba = 3'h0;
      addr = 14'h0000;
   end
   // One command cycle, then deselect with the stale address scrambled
   task automatic cyc(input logic k, input logic [3:0] c, input logic [2:0] b,
         input logic [13:0] a);
      @(posedge clk_sys);
      #1;
      cke = k;
      {cs_n, ras_n, cas_n, we_n} = c;
      ba = b;
      addr = a;
      @(posedge clk_sys);
      #1;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      addr = ~addr;
   endtask
   // Mode write from idle only, reserved bits cleared
   task automatic mrs(input logic [2:0] b, input logic [13:0] a);
      logic [13:0] m;
      m = a & 14'h1FFF;
      if (b == 3'h0) m[7] = 1'b0;
      if (b == 3'h1) m = m & 14'h3AFF;
      if (b == 3'h1) dll_off = m[0];
      if (dll_off && b == 3'h1) m = m & 14'h3DBB;
      if (dll_off && b == 3'h2) m = m & 14'h39FF;
      cyc(1'b1, dmrc_pkg::CMD_MRS, b, m);
   endtask
endmodule
`default_nettype wire

//--- verification/dram_mode_register_config_tb.sv
// Self-checking bench for the mode register block
`timescale 1ns/10ps
`default_nettype none
module dram_mode_register_config_tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   wire logic cke, cs_n, ras_n, cas_n, we_n;
   wire logic [2:0] ba;
   wire logic [13:0] addr;
   wire logic [4:0] cas_latency, additive_latency, read_latency, write_latency, dal;
   wire logic al_reserved, test_mode, write_leveling, tdqs_enable, outputs_off;
   wire logic [1:0] drive_strength, rtt_wr;
   wire logic [2:0] rtt_nom;
   wire logic dll_running, dll_locked, write_term_ok, cmd_ready;
   wire logic rd_issue, wr_issue, rd_data_start, wr_data_start;
   int error_cnt = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [4:0] wr_tab [8] = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E};
   always #5 clk_sys = ~clk_sys;
   dmrc_ctrl_model u_m (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
   dmrc_top dut (.clk_sys(clk_sys), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .cas_latency(cas_latency),
      .additive_latency(additive_latency), .read_latency(read_latency),
      .write_latency(write_latency), .autoprecharge_to_activate_delay(dal),
      .al_reserved(al_reserved), .test_mode(test_mode), .drive_strength(drive_strength),
      .rtt_nom(rtt_nom), .rtt_wr(rtt_wr), .write_leveling(write_leveling),
      .tdqs_enable(tdqs_enable), .outputs_off(outputs_off), .dll_running(dll_running),
      .dll_locked(dll_locked), .write_term_ok(write_term_ok), .cmd_ready(cmd_ready),
      .rd_issue(rd_issue), .wr_issue(wr_issue), .rd_data_start(rd_data_start),
      .wr_data_start(wr_data_start));
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic step(inout int k, input int lim);
      @(posedge clk_sys);
      #1;
      k++;
      if (k > lim) k = lim;
   endtask
   // Cycles from command to internal issue, then to first data
   task automatic meas(input logic rd, input int n_iss, input int n_dat);
      int k;
      u_m.cyc(1'b1, rd ? dmrc_pkg::CMD_RD : dmrc_pkg::CMD_WR, 3'h0, 14'h0000);
      // A pulse standing now is sampled at the next edge
      k = 1;
      while (((rd ? rd_issue : wr_issue) !== 1'b1) && k < 60) step(k, 60);
      chk(k, n_iss);
      k = 0;
      while (((rd ? rd_data_start : wr_data_start) !== 1'b1) && k < 60) step(k, 60);
      chk(k, n_dat);
   endtask
   task automatic wait_lock(output int k);
      k = 3;
      while (dll_locked !== 1'b1 && k < 800) step(k, 800);
   endtask
   task automatic pdown(input logic ppd, output int w);
      u_m.mrs(3'h0, {1'b0, ppd, 12'h000});
      u_m.cyc(1'b0, 4'hF, 3'h0, 14'h0000);
      @(posedge clk_sys);
      #1;
      chk(cmd_ready, 0);
      chk(dll_running, ppd);
      u_m.cyc(1'b1, 4'hF, 3'h0, 14'h0000);
      w = 0;
      while (cmd_ready !== 1'b1 && w < 20) step(w, 20);
   endtask
   initial begin
      int i, k, wf, ws;
      logic [3:0] cl4;
      logic [4:0] cl, al;
      logic [13:0] a0, a1;
      repeat (16) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(cas_latency, 4);
      chk(write_latency, 5);
      chk(dal, 18);
      chk(cmd_ready, 1);
      // DLL reset clears itself and relocks once
      u_m.mrs(3'h0, 14'h0100);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(dll_locked, 0);
      chk(write_term_ok, 1);
      wait_lock(k);
      chk(k >= 512 && k <= 516, 1);
      for (i = 0; i < 8; i++) begin
         cl4 = {i == 1, i[2:0]};
         a0 = 14'h0000;
         a0[2] = cl4[3];
         a0[6:4] = cl4[2:0];
         a0[11:9] = i[2:0];
         a0[12] = i[0];
         u_m.mrs(3'h0, a0);
         a1 = {1'b0, i == 5, i[2], 1'b0, i[1], 1'b0, i == 4, i[0], i[1], i[1:0], i[2], i[0],
            1'b0};
         u_m.mrs(3'h1, a1);
         u_m.mrs(3'h2, {3'h0, i[1:0], 3'h0, i[2:0], 3'h0});
         repeat (3) @(posedge clk_sys);
         #1;
         cl = cl4[3] ? 5'h0B + cl4[2:0] : 5'h04 + cl4[2:0];
         al = i[1:0] == 2'h1 ? cl - 5'h01 : i[1:0] == 2'h2 ? cl - 5'h02 : 5'h00;
         chk(cas_latency, cl);
         chk(additive_latency, al);
         chk(al_reserved, i[1:0] == 2'h3);
         chk(read_latency, al + cl);
         chk(write_latency, al + 5 + i);
         chk(dal, wr_tab[i] + 2);
         chk(test_mode, 0);
         chk(drive_strength, i[1:0]);
         chk(rtt_nom, {i[1], i[0], i[2]});
         chk(rtt_wr, i[1:0]);
         chk({write_leveling, tdqs_enable, outputs_off}, {i == 4, i[2], i == 5});
         meas(1'b1, al + 1, cl);
         meas(1'b0, al + 1, 5 + i);
      end
      pdown(1'b1, wf);
      pdown(1'b0, ws);
      chk(ws - wf, 2);
      chk(wf >= 1 && wf <= 2, 1);
      // Self refresh stops the DLL and relocks on exit
      u_m.cyc(1'b0, dmrc_pkg::CMD_REF, 3'h0, 14'h0000);
      @(posedge clk_sys);
      #1;
      chk(dll_running, 0);
      u_m.cyc(1'b1, 4'hF, 3'h0, 14'h0000);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(dll_running, 1);
      chk(write_term_ok, 0);
      wait_lock(k);
      chk(dll_locked, 1);
      // DLL-off mode, termination turned off, writes still work
      u_m.mrs(3'h1, 14'h0245);
      u_m.mrs(3'h2, 14'h0600);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(dll_running, 0);
      chk(dll_locked, 0);
      chk(rtt_nom, 0);
      chk(rtt_wr, 0);
      chk(write_term_ok, 1);
      meas(1'b0, 1, 5);
      // DLL enabled again, then reset, lock restarts
      u_m.mrs(3'h1, 14'h0000);
      u_m.mrs(3'h0, 14'h0100);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(dll_locked, 0);
      // Mid-run reset returns registers and lock counter to zero
      resetn = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(cas_latency, 4);
      chk(write_latency, 5);
      chk(dal, 18);
      chk(dll_locked, 1);
      chk(cmd_ready, 1);
      conclude();
   end
endmodule
`default_nettype wire
